/* File: dsp_reset_boot_sequencer.sv */
// Device reset release, boot mode sequencing and test reset handling.
// Assumes all inputs, test clock included, are synchronous to clk.
//
// Our own choices: the strobed register port and the register addresses.
`default_nettype none
// What this block does and what it relies on from outside
// RULE_01 - Hold reset state, then start with config
// RULE_02 - Exactly three boot modes supported
// RULE_03 - Host boot stalls CPU, rest leaves reset
// RULE_04 - Host may read and write all memory; code drops host writes while the ROM copy runs
// RULE_05 - PCI enable picks PCI or host port
// RULE_06 - Host interrupt bit ends stall, start zero
// RULE_07 - Stall release not pending; host mode only
// RULE_08 - Bit set blocks more host interrupts
// RULE_09 - ROM boot copies 1K image, CPU stalled
// RULE_10 - Bytes packed into words by endianness
// RULE_11 - Single block copy, then run from zero
// RULE_12 - No boot runs from zero immediately
// RULE_13 - Both resets asserted at power-up
// RULE_14 - Test clock runs during test reset
// RULE_15 - Device boots with test reset held
// RULE_16 - Variant field valid only after reset
// RULE_17 - Test reset rise latches emulation pins; code latches only once the core left reset
// RULE_18 - Undriven test reset reads as asserted
// RULE_19 - Controller drives test reset high before use
// RULE_20 - Reset held low until clock stable
// RULE_21 - Clock correct before reset release
// RULE_22 - Config sampled at reset release, held
module dsp_reset_boot_sequencer #(
  parameter bit HAS_PCI = 1'b1,
  parameter logic [3:0] VARIANT = 4'h5,
  parameter int ROM_WAIT = boot_seq_pkg::ROM_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] boot_mode_cfg,
  input wire logic pci_enable_cfg,
  input wire logic big_endian_cfg,
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rd_data,
  input wire logic cpu_clear_host_int,
  input wire logic [7:0] rom_data,
  output logic [9:0] rom_addr,
  output logic rom_rd,
  input wire logic test_clk,
  input wire logic test_rst_level,
  input wire logic test_rst_driven,
  input wire logic emulation_config_pin_high,
  input wire logic emulation_config_pin_low,
  output logic cpu_stall,
  output logic cpu_run,
  output logic [31:0] cpu_start_addr,
  output logic cpu_host_irq,
  output logic periph_rst_b,
  output logic host_via_pci,
  output logic emu_rst_b,
  output logic boundary_scan_enable,
  output logic [1:0] emu_mode,
  output logic [3:0] idcode_variant,
  output logic idcode_valid
);
  typedef struct packed {
    boot_seq_pkg::boot_state_type state;
    logic [1:0] mode;
    logic pci;
    logic big;
    logic host_int;
    logic irq;
    logic [31:0] rd_data;
    logic stall;
    logic run;
    logic [31:0] start_addr;
    logic periph_rst_b;
    logic dma_start;
    logic tck_q;
    logic trst_q;
    logic [1:0] emu;
    logic [3:0] variant;
    logic id_valid;
  } top_state_type;
  top_state_type s_reg;
  top_state_type s_next;

  logic dma_we;
  logic [7:0] dma_idx;
  logic [31:0] dma_word;
  logic dma_done;
  logic host_we;
  logic [31:0] mem_rd_word;
  logic in_mem;
  logic trst_eff;
  logic host_set;
  logic tck_rise;

  function automatic logic [1:0] legal_mode(input logic [1:0] m);
    // Unused code falls back to direct execution
    if (m == boot_seq_pkg::BOOT_HOST || m == boot_seq_pkg::BOOT_ROM) begin
      return m;
    end
    return boot_seq_pkg::BOOT_NONE;
  endfunction

  // One decode for the memory window, shared by writes and reads
  function automatic logic mem_window(input logic [11:0] a);
    return a >= boot_seq_pkg::MEM_BASE;
  endfunction

  // Every way out of the stall starts the core at the same address
  function automatic top_state_type release_to_run(input top_state_type s);
    top_state_type r;
    r = s;
    r.state = boot_seq_pkg::ST_RUN;
    r.stall = 1'b0;
    r.run = 1'b1;
    r.irq = 1'b0; // RULE_07
    r.start_addr = boot_seq_pkg::CPU_START_ADDR;
    return r;
  endfunction

  // Register view; unmapped offsets read as zero
  function automatic logic [31:0] reg_read(input logic [11:0] a, input top_state_type s);
    logic [31:0] r;
    case (a)
      boot_seq_pkg::OFS_HOST_CTRL: begin
        r = {31'h0000_0000, s.host_int};
      end
      boot_seq_pkg::OFS_STATUS: begin
        r = {22'h00_0000, s.emu, s.trst_q, s.periph_rst_b, s.state, s.run,
             s.stall};
      end
      boot_seq_pkg::OFS_CONFIG: begin
        r = {28'h000_0000, s.big, s.pci, s.mode};
      end
      boot_seq_pkg::OFS_ID: begin
        r = {27'h000_0000, s.id_valid, s.variant};
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction

  // Core reset only; the test reset domain keeps its own state
  function automatic top_state_type core_reset(input top_state_type s);
    top_state_type r;
    r = '0;
    r.state = boot_seq_pkg::ST_RESET;
    r.stall = 1'b1;
    r.periph_rst_b = 1'b0; // RULE_03
    r.start_addr = boot_seq_pkg::CPU_START_ADDR;
    r.variant = boot_seq_pkg::VARIANT_RESET;
    r.tck_q = s.tck_q;
    r.trst_q = s.trst_q; // RULE_15
    r.emu = s.emu;
    return r;
  endfunction

  always_comb begin
    in_mem = mem_window(addr);
    trst_eff = test_rst_driven & test_rst_level; // RULE_18
    host_set = wr && (addr == boot_seq_pkg::OFS_HOST_CTRL) &&
               wr_data[boot_seq_pkg::HOST_INT_BIT];
    host_we = wr && in_mem && (s_reg.state != boot_seq_pkg::ST_ROM_COPY); // RULE_04
    tck_rise = test_clk && !s_reg.tck_q;
  end

  always_comb begin
    s_next = s_reg;
    s_next.irq = 1'b0;
    s_next.dma_start = 1'b0;
    s_next.rd_data = 32'h0000_0000;

    case (s_reg.state)
      boot_seq_pkg::ST_RESET: begin
        // First edge after release samples the straps once
        s_next.mode = legal_mode(boot_mode_cfg); // RULE_22
        s_next.pci = HAS_PCI & pci_enable_cfg; // RULE_05
        s_next.big = big_endian_cfg;
        s_next.periph_rst_b = 1'b1; // RULE_03
        s_next.start_addr = boot_seq_pkg::CPU_START_ADDR;
        case (legal_mode(boot_mode_cfg)) // RULE_02
          boot_seq_pkg::BOOT_HOST: begin
            s_next.state = boot_seq_pkg::ST_HOST_STALL; // RULE_03
          end
          boot_seq_pkg::BOOT_ROM: begin
            s_next.state = boot_seq_pkg::ST_ROM_COPY; // RULE_09
            s_next.dma_start = 1'b1;
          end
          default: begin
            s_next = release_to_run(s_next); // RULE_12
          end
        endcase
      end
      boot_seq_pkg::ST_HOST_STALL: begin
        if (host_set && !s_reg.host_int) begin
          // Release only; no pending interrupt reaches the CPU
          s_next = release_to_run(s_next); // RULE_06
          s_next.host_int = 1'b1; // RULE_07
        end
      end
      boot_seq_pkg::ST_ROM_COPY: begin
        if (dma_done) begin
          s_next = release_to_run(s_next); // RULE_11
        end
      end
      boot_seq_pkg::ST_RUN: begin
        if (cpu_clear_host_int) begin
          s_next.host_int = 1'b0;
        end
        // Held bit refuses new sets, even when a clear comes in the same cycle
        if (host_set && !s_reg.host_int) begin // RULE_08
          s_next.host_int = 1'b1;
          s_next.irq = 1'b1;
        end
      end
      default: begin
        s_next.state = boot_seq_pkg::ST_RESET;
      end
    endcase

    if (rd) begin
      if (in_mem) begin
        s_next.rd_data = mem_rd_word; // RULE_04
      end else begin
        s_next.rd_data = reg_read(addr, s_reg);
      end
    end

    // Test reset is seen only on test clock edges
    s_next.tck_q = test_clk; // RULE_14
    if (tck_rise) begin
      s_next.trst_q = trst_eff;
      // A rising test reset counts only once the core left reset
      if (!s_reg.trst_q && trst_eff && s_reg.periph_rst_b) begin
        s_next.emu = {emulation_config_pin_high, emulation_config_pin_low}; // RULE_17
      end
    end
    // Variant field is only trustworthy once the core left reset
    s_next.variant = s_reg.periph_rst_b ? VARIANT : boot_seq_pkg::VARIANT_RESET; // RULE_16
    s_next.id_valid = s_reg.periph_rst_b;

    if (!rst_b) begin
      // Test clock and test reset keep being sampled through core reset
      s_next = core_reset(s_next); // RULE_01
    end
    // Pulled-down test reset clears emulation logic at power-up
    if (tck_rise && !trst_eff) begin // RULE_13
      s_next.emu = boot_seq_pkg::EMU_RESET;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  rom_copy_dma #(
    .IMAGE_BYTES(boot_seq_pkg::ROM_IMAGE_BYTES),
    .ROM_WAIT(ROM_WAIT)
  ) u_dma (
    .clk(clk),
    .rst_b(rst_b),
    .start(s_reg.dma_start), // RULE_09
    .big_endian(s_reg.big),
    .rom_data(rom_data),
    .rom_addr(rom_addr),
    .rom_rd(rom_rd),
    .mem_we(dma_we),
    .mem_idx(dma_idx),
    .mem_word(dma_word),
    .done(dma_done)
  );

  boot_mem #(
    .WORDS(boot_seq_pkg::ROM_IMAGE_WORDS),
    .IDX_W(8)
  ) u_mem (
    .clk(clk),
    .dma_we(dma_we),
    .dma_idx(dma_idx),
    .dma_word(dma_word),
    .host_we(host_we),
    .host_idx(addr[9:2]),
    .host_word(wr_data),
    .rd_idx(addr[9:2]),
    .rd_word(mem_rd_word)
  );

  assign rd_data = s_reg.rd_data;
  assign cpu_stall = s_reg.stall;
  assign cpu_run = s_reg.run;
  assign cpu_start_addr = s_reg.start_addr;
  assign cpu_host_irq = s_reg.irq;
  assign periph_rst_b = s_reg.periph_rst_b;
  assign host_via_pci = s_reg.pci;
  assign emu_rst_b = s_reg.trst_q;
  assign boundary_scan_enable = s_reg.trst_q;
  assign emu_mode = s_reg.emu;
  assign idcode_variant = s_reg.variant;
  assign idcode_valid = s_reg.id_valid;
endmodule
`default_nettype wire

/* File: boot_seq_pkg.sv */
// Shared constants and types for the reset and boot sequencer.
// Assumes one clock domain and a synchronous active-low device reset.
`default_nettype none
package boot_seq_pkg;
  localparam logic [11:0] OFS_HOST_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CONFIG = 12'h008;
  localparam logic [11:0] OFS_ID = 12'h00C;
  localparam logic [11:0] MEM_BASE = 12'h400;
  localparam int HOST_INT_BIT = 0;
  localparam logic [1:0] BOOT_NONE = 2'h0;
  localparam logic [1:0] BOOT_HOST = 2'h1;
  localparam logic [1:0] BOOT_ROM = 2'h2;
  localparam int ROM_IMAGE_BYTES = 1024;
  localparam int WORD_BYTES = 4;
  localparam int ROM_IMAGE_WORDS = ROM_IMAGE_BYTES / WORD_BYTES;
  localparam int ROM_WAIT_CYCLES = 4;
  localparam logic [31:0] CPU_START_ADDR = 32'h0000_0000;
  localparam logic [3:0] VARIANT_RESET = 4'h0;
  localparam logic [1:0] EMU_RESET = 2'h0;
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_HOST_STALL = 4'h2,
    ST_ROM_COPY = 4'h4,
    ST_RUN = 4'h8
  } boot_state_type;
  typedef enum logic [2:0] {
    DMA_IDLE = 3'h1,
    DMA_FETCH = 3'h2,
    DMA_DONE = 3'h4
  } dma_state_type;
endpackage
`default_nettype wire

/* File: boot_mem.sv */
// Flip-flop memory at address 0 with a copy port and a host port.
// Assumes the copy port and host port never write in the same cycle, whatever the word.
`default_nettype none
module boot_mem #(
  parameter int WORDS = boot_seq_pkg::ROM_IMAGE_WORDS,
  parameter int IDX_W = 8
) (
  input wire logic clk,
  input wire logic dma_we,
  input wire logic [IDX_W-1:0] dma_idx,
  input wire logic [31:0] dma_word,
  input wire logic host_we,
  input wire logic [IDX_W-1:0] host_idx,
  input wire logic [31:0] host_word,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [31:0] rd_word
);
  typedef struct packed {
    logic [WORDS-1:0][31:0] mem;
  } mem_state_type;
  mem_state_type s_reg;
  mem_state_type s_next;

  always_comb begin
    s_next = s_reg;
    // Copy port wins so a stray host write cannot corrupt the image
    if (dma_we) begin
      s_next.mem[dma_idx] = dma_word;
    end else if (host_we) begin
      s_next.mem[host_idx] = host_word;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign rd_word = s_reg.mem[rd_idx];
endmodule
`default_nettype wire

/* File: rom_copy_dma.sv */
// Byte-wide boot ROM copier that packs bytes into 32-bit words.
// Assumes the ROM answers within the fixed wait given by ROM_WAIT.
`default_nettype none
module rom_copy_dma #(
  parameter int IMAGE_BYTES = boot_seq_pkg::ROM_IMAGE_BYTES,
  parameter int ROM_WAIT = boot_seq_pkg::ROM_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic big_endian,
  input wire logic [7:0] rom_data,
  output logic [9:0] rom_addr,
  output logic rom_rd,
  output logic mem_we,
  output logic [7:0] mem_idx,
  output logic [31:0] mem_word,
  output logic done
);
  typedef struct packed {
    boot_seq_pkg::dma_state_type state;
    logic [9:0] addr;
    logic [7:0] wait_cnt;
    logic [31:0] word;
    logic rd;
    logic we;
    logic [7:0] idx;
    logic [31:0] out_word;
  } dma_state_struct_type;
  dma_state_struct_type s_reg;
  dma_state_struct_type s_next;
  localparam logic [7:0] WAIT_LAST = 8'(ROM_WAIT - 1);
  localparam logic [9:0] ADDR_LAST = 10'(IMAGE_BYTES - 1);

  function automatic logic [31:0] pack_byte(input logic [31:0] w, input logic [7:0] b,
                                            input logic [1:0] lane, input logic big);
    logic [31:0] r;
    r = w;
    if (big) begin
      r[8*(3-lane) +: 8] = b;
    end else begin
      r[8*lane +: 8] = b;
    end
    return r;
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.we = 1'b0;
    case (s_reg.state)
      boot_seq_pkg::DMA_IDLE: begin
        if (start) begin
          s_next.state = boot_seq_pkg::DMA_FETCH;
          s_next.rd = 1'b1;
        end
      end
      boot_seq_pkg::DMA_FETCH: begin
        s_next.wait_cnt = s_reg.wait_cnt + 8'h01;
        if (s_reg.wait_cnt == WAIT_LAST) begin
          s_next.wait_cnt = 8'h00;
          s_next.word = pack_byte(s_reg.word, rom_data, s_reg.addr[1:0], big_endian); // RULE_10
          if (s_reg.addr[1:0] == 2'h3) begin
            s_next.we = 1'b1;
            s_next.idx = s_reg.addr[9:2];
            s_next.out_word = s_next.word;
          end
          s_next.addr = s_reg.addr + 10'h001;
          // One block, one frame, then stop for good
          if (s_reg.addr == ADDR_LAST) begin // RULE_11
            s_next.state = boot_seq_pkg::DMA_DONE;
            s_next.rd = 1'b0;
          end
        end
      end
      boot_seq_pkg::DMA_DONE: begin
        s_next.rd = 1'b0;
      end
      default: begin
        s_next.state = boot_seq_pkg::DMA_IDLE;
      end
    endcase
    if (!rst_b) begin
      s_next = '0;
      s_next.state = boot_seq_pkg::DMA_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign rom_addr = s_reg.addr;
  assign rom_rd = s_reg.rd;
  assign mem_we = s_reg.we;
  assign mem_idx = s_reg.idx;
  assign mem_word = s_reg.out_word;
  assign done = (s_reg.state == boot_seq_pkg::DMA_DONE);
endmodule
`default_nettype wire

/* File: boot_rom_model.sv */
// Byte-wide boot ROM on chip-enable space one, answering at once.
// Assumes the sequencer samples a byte only while its read strobe is high.
`default_nettype none
module boot_rom_model (
  input wire logic clk,
  input wire logic [9:0] rom_addr,
  input wire logic rom_rd,
  output logic [7:0] rom_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_reg;
  // Image byte pattern; differs from its address so packing slips show
  function automatic logic [7:0] rb(input logic [9:0] a);
    return a[7:0] ^ {a[9:8], 6'h2A};
  endfunction
  always_ff @(posedge clk) begin
    if (rom_rd) begin
      last_reg <= rb(rom_addr);
    end
  end
  // Released bus shows the inverse of the last byte, never a stale copy
  assign rom_data = rom_rd ? rb(rom_addr) : ~last_reg;
endmodule
`default_nettype wire

/* File: boot_seq_sva.sv */
// Checker for the reset and boot sequencer, bound to its top module.
// Assumes the bench holds the emulation pins steady around a test reset rise.
`default_nettype none
module boot_seq_sva #(
  parameter logic [3:0] VARIANT = 4'h5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] boot_mode_cfg,
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rd_data,
  input wire logic [9:0] rom_addr,
  input wire logic rom_rd,
  input wire logic emulation_config_pin_high,
  input wire logic emulation_config_pin_low,
  input wire logic cpu_stall,
  input wire logic cpu_run,
  input wire logic [31:0] cpu_start_addr,
  input wire logic cpu_host_irq,
  input wire logic periph_rst_b,
  input wire logic emu_rst_b,
  input wire logic [1:0] emu_mode,
  input wire logic [3:0] idcode_variant,
  input wire logic idcode_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rst_q;
  logic [1:0] mode_q;
  logic rel;
  logic host_set;
  always_ff @(posedge clk) begin
    rst_q <= rst_b;
    if (rst_b && !rst_q) begin
      mode_q <= boot_mode_cfg;
    end
  end
  assign rel = rst_b && !rst_q;
  assign host_set = wr && addr == boot_seq_pkg::OFS_HOST_CTRL && wr_data[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rst_hold;
    @(posedge clk) disable iff (1'b0)
    !rst_b |=> cpu_stall && !cpu_run && !periph_rst_b && !idcode_valid;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset state wrong");
  property p_host_stall;
    rel && boot_mode_cfg == boot_seq_pkg::BOOT_HOST |=> cpu_stall && !cpu_run && periph_rst_b;
  endproperty
  a_host_stall: assert property (p_host_stall) else $error("host stall wrong");
  property p_none_run;
    rel && boot_mode_cfg[1] == boot_mode_cfg[0]
      |=> cpu_run && !cpu_stall && cpu_start_addr == boot_seq_pkg::CPU_START_ADDR;
  endproperty
  a_none_run: assert property (p_none_run) else $error("no boot start wrong");
  property p_rom_start;
    rel && boot_mode_cfg == boot_seq_pkg::BOOT_ROM
      |=> cpu_stall && !cpu_run ##1 rom_rd && rom_addr == 10'h000;
  endproperty
  a_rom_start: assert property (p_rom_start) else $error("rom copy start wrong");
  property p_rom_step;
    rom_rd && $past(rom_rd) && $changed(rom_addr) |-> rom_addr == $past(rom_addr) + 10'h001;
  endproperty
  a_rom_step: assert property (p_rom_step) else $error("rom address skip");
  property p_host_release;
    mode_q == boot_seq_pkg::BOOT_HOST && cpu_stall && periph_rst_b && host_set
      |=> !cpu_stall && cpu_run && !cpu_host_irq;
  endproperty
  a_host_release: assert property (p_host_release) else $error("release wrong");
  property p_no_release;
    mode_q != boot_seq_pkg::BOOT_HOST && cpu_stall && periph_rst_b && host_set |=> cpu_stall;
  endproperty
  a_no_release: assert property (p_no_release) else $error("stall left");
  property p_irq_cause;
    cpu_host_irq |-> $past(host_set) && $past(cpu_run);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_irq_pulse;
    cpu_host_irq |=> !cpu_host_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_rd_idle;
    !rd |=> rd_data == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_id_valid;
    rel |=> ##1 idcode_valid && idcode_variant == VARIANT;
  endproperty
  a_id_valid: assert property (p_id_valid) else $error("variant wrong");
  property p_emu_latch;
    $rose(emu_rst_b) && $past(periph_rst_b)
      |-> emu_mode == {emulation_config_pin_high, emulation_config_pin_low};
  endproperty
  a_emu_latch: assert property (p_emu_latch) else $error("emulation pins wrong");
  c_irq: cover property (cpu_host_irq);
  c_rom_end: cover property (rom_rd ##1 !rom_rd);
  c_emu: cover property ($rose(emu_rst_b));
endmodule
bind dsp_reset_boot_sequencer boot_seq_sva #(.VARIANT(VARIANT)) u_boot_seq_sva (.clk, .rst_b,
  .boot_mode_cfg, .addr, .wr_data, .wr, .rd, .rd_data, .rom_addr, .rom_rd,
  .emulation_config_pin_high, .emulation_config_pin_low, .cpu_stall, .cpu_run,
  .cpu_start_addr, .cpu_host_irq, .periph_rst_b, .emu_rst_b, .emu_mode, .idcode_variant,
  .idcode_valid);
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench: host, ROM and no boot, host interrupt, test reset.
// Assumes the ROM model answers at once, so ROM_WAIT is set to 1.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, pci_enable_cfg, big_endian_cfg, wr, rd, cpu_clear_host_int, rom_rd;
  logic test_clk = 1'b0;
  logic test_rst_level, test_rst_driven;
  logic emulation_config_pin_high, emulation_config_pin_low;
  logic cpu_stall, cpu_run, cpu_host_irq, periph_rst_b, host_via_pci, emu_rst_b;
  logic boundary_scan_enable, idcode_valid;
  logic [1:0] boot_mode_cfg, emu_mode;
  logic [3:0] idcode_variant;
  logic [7:0] rom_data;
  logic [9:0] rom_addr;
  logic [11:0] addr;
  logic [31:0] wr_data, rd_data, cpu_start_addr;
  int err_count, compares, cyc, n;
  localparam logic [3:0] VAR = 4'hA; // Arbitrary variant code
  dsp_reset_boot_sequencer #(.VARIANT(VAR), .ROM_WAIT(1)) u_dsp_reset_boot_sequencer (.clk,
    .rst_b, .boot_mode_cfg, .pci_enable_cfg, .big_endian_cfg, .addr, .wr_data, .wr, .rd,
    .rd_data, .cpu_clear_host_int, .rom_data, .rom_addr, .rom_rd, .test_clk, .test_rst_level,
    .test_rst_driven, .emulation_config_pin_high, .emulation_config_pin_low, .cpu_stall,
    .cpu_run, .cpu_start_addr, .cpu_host_irq, .periph_rst_b, .host_via_pci, .emu_rst_b,
    .boundary_scan_enable, .emu_mode, .idcode_variant, .idcode_valid);
  boot_rom_model u_boot_rom_model (.clk, .rom_addr, .rom_rd, .rom_data);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) test_clk <= ~test_clk;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task wrap_up;
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr_t(input logic [11:0] a, input logic [31:0] d);
    wr <= 1'b1; addr <= a; wr_data <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rd_t(input string nm, input logic [11:0] a, input logic [31:0] e);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rd_data, e);
  endtask
  task boot(input logic [1:0] m, input logic big);
    rst_b <= 1'b0; boot_mode_cfg <= m; big_endian_cfg <= big;
    repeat (10) @(posedge clk);
    #1;
    chk("reset state", 32'({periph_rst_b, cpu_stall, cpu_run}), 32'h2);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] rom_word(input int i, input logic big);
    logic [7:0] b [4];
    for (int k = 0; k < 4; k++) b[k] = 8'(4 * i + k) ^ {2'(i >> 6), 6'h2A};
    return big ? {b[0], b[1], b[2], b[3]} : {b[3], b[2], b[1], b[0]};
  endfunction
  initial begin
    rst_b = 1'b0; boot_mode_cfg = 2'h0; pci_enable_cfg = 1'b1; big_endian_cfg = 1'b0;
    addr = 12'h000; wr_data = 32'h0; wr = 1'b0; rd = 1'b0; cpu_clear_host_int = 1'b0;
    test_rst_level = 1'b1; test_rst_driven = 1'b0;
    emulation_config_pin_high = 1'b0; emulation_config_pin_low = 1'b0;
    err_count = 0; compares = 0;
    boot(boot_seq_pkg::BOOT_HOST, 1'b0);
    chk("host stall", 32'({cpu_stall, cpu_run, periph_rst_b}), 32'h5);
    boot_mode_cfg <= 2'h2;
    pci_enable_cfg <= 1'b0;
    rd_t("config", boot_seq_pkg::OFS_CONFIG, 32'h5);
    chk("pci select", 32'(host_via_pci), 32'h1);
    for (int i = 0; i < 256; i += 255) begin
      wr_t(boot_seq_pkg::MEM_BASE + 12'(4 * i), 32'hA5C3_0F96 ^ i);
      rd_t("memory", boot_seq_pkg::MEM_BASE + 12'(4 * i), 32'hA5C3_0F96 ^ i);
    end
    wr_t(12'h010, 32'hFFFF_FFFF);
    rd_t("unmapped", 12'h010, 32'h0);
    wr_t(boot_seq_pkg::OFS_HOST_CTRL, 32'h1);
    chk("release", 32'({cpu_stall, cpu_run, cpu_host_irq}), 32'h2);
    chk("start address", cpu_start_addr, 32'h0);
    rd_t("host bit set", boot_seq_pkg::OFS_HOST_CTRL, 32'h1);
    wr_t(boot_seq_pkg::OFS_HOST_CTRL, 32'h1);
    chk("irq blocked", 32'(cpu_host_irq), 32'h0);
    cpu_clear_host_int <= 1'b1;
    @(posedge clk);
    cpu_clear_host_int <= 1'b0;
    #1;
    rd_t("host bit clear", boot_seq_pkg::OFS_HOST_CTRL, 32'h0);
    wr_t(boot_seq_pkg::OFS_HOST_CTRL, 32'h1);
    chk("irq", 32'(cpu_host_irq), 32'h1);
    rd_t("id", boot_seq_pkg::OFS_ID, {27'h0, 1'b1, VAR});
    chk("test reset undriven", 32'(emu_rst_b), 32'h0);
    test_rst_driven <= 1'b1; test_rst_level <= 1'b0;
    emulation_config_pin_high <= 1'b1;
    repeat (20) @(posedge clk);
    test_rst_level <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk("emulation", 32'({emu_rst_b, boundary_scan_enable, emu_mode}), 32'hE);
    rd_t("status", boot_seq_pkg::OFS_STATUS, 32'h0000_02E2);
    for (int big = 0; big < 2; big++) begin
      boot(boot_seq_pkg::BOOT_ROM, big[0]);
      wr_t(boot_seq_pkg::MEM_BASE, 32'h0);
      wr_t(boot_seq_pkg::OFS_HOST_CTRL, 32'h1);
      chk("rom stall", 32'({cpu_stall, cpu_run}), 32'h2);
      n = 0;
      while (cpu_run !== 1'b1 && n < 4000) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("rom done", 32'({cpu_stall, cpu_run}), 32'h1);
      rd_t("rom config", boot_seq_pkg::OFS_CONFIG, {28'h0, big[0], 3'h2});
      for (int i = 0; i < 256; i += 85) begin
        rd_t("rom word", boot_seq_pkg::MEM_BASE + 12'(4 * i), rom_word(i, big[0]));
      end
    end
    for (int m = 0; m < 4; m += 3) begin
      boot(2'(m), 1'b0);
      chk("no boot", 32'({cpu_stall, cpu_run, host_via_pci}), 32'h2);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
